// File: hdl/mccr_regs.sv
// conversion configuration register bank: two 8-bit registers plus their control outputs
// assumes a simple synchronous register port from the serial interface and one clock
// Operation
// - select code picks single conversion source
// - code 010 follows pin 7/8 function
// - mode bit: round robin or single
// - averaging 16 times unless disabled
// - timeout releases data after 25 ms
// - software reset restores all defaults
// - speed bit picks 1.4k or 22.5k
// - resolution bit picks 8 or 10
// - load source: pin or registers
// - reference bit: internal or supply
// - dac a tracks internal temperature
// - dac b tracks external temperature
// - both registers reset to zero
// - load source ignored while pin is input
// - no conversion before monitoring start
module mccr_regs
	import mccr_pkg::*;
#(
	parameter int TIMEOUT_CYC = MCCR_TIMEOUT_CYC,
	parameter int SLOW_DIV    = MCCR_SLOW_DIV,
	parameter int FAST_DIV    = MCCR_FAST_DIV,
	parameter int AVG_COUNT   = MCCR_AVG_COUNT
)
(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [7:0] reg_addr,          // register address
	input  wire logic       reg_write,         // write strobe
	input  wire logic [7:0] reg_wdata,         // write data
	output logic      [7:0] reg_rdata,         // read data of reg_addr
	input  wire logic [7:0] first_control,     // first control register value
	input  wire logic       serial_clock_low,  // serial clock held low
	input  wire logic       in_transaction,    // serial transfer in progress
	output logic            bus_abort,         // pulse: abandon and release data
	output logic            soft_reset,        // pulse: reset rest of device
	output logic            conv_tick,         // pulse: start one conversion
	output logic [6:0]      conv_source,       // one-hot resolved source
	output logic            single_mode,       // 1 = single channel cycle
	output logic [4:0]      avg_count,         // results per measurement
	output logic            fast_adc,          // fast clock, diode filter bypass
	output logic            thermal_10bit,     // thermal output resolution
	output logic            load_from_regs,    // registers update dacs
	output logic            load_from_pin,     // dac_load_strobe updates dacs
	output logic            adc_ref_supply,    // supply as adc reference
	output logic            dac_a_track,       // dac a follows internal temp
	output logic            dac_b_track        // dac b follows external temp
);
	////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0]  conversion_control;
	logic [7:0]  converter_output_control;
	logic [7:0]  next_conversion_control;
	logic [7:0]  next_converter_output_control;
	logic        next_soft_reset;
	logic        sw_reset_hit;  // write of 1 to the reset bit

	// next register values
	always_comb
	begin
		next_conversion_control       = conversion_control;
		next_converter_output_control = converter_output_control;
		sw_reset_hit = reg_write && reg_addr == MCCR_ADDR_CONV_CTRL
			&& reg_wdata[MCCR_SWRST_BIT];
		next_soft_reset = sw_reset_hit;
		if (sw_reset_hit)  // reset wins over the rest of the write
		begin
			next_conversion_control       = MCCR_RESET_VALUE;
			next_converter_output_control = MCCR_RESET_VALUE;
		end
		else if (reg_write && reg_addr == MCCR_ADDR_CONV_CTRL)
		begin
			// reserved bits kept zero whatever the host writes
			next_conversion_control = reg_wdata & MCCR_CONV_WMASK;
		end
		else if (reg_write && reg_addr == MCCR_ADDR_OUT_CTRL)
		begin
			next_converter_output_control = reg_wdata & MCCR_OUT_WMASK;
		end
	end

	// register stage
	// soft_reset comes from a flop so the rest of the device sees a clean pulse
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			conversion_control       <= MCCR_RESET_VALUE;
			converter_output_control <= MCCR_RESET_VALUE;
			soft_reset               <= 1'b0;
		end
		else
		begin
			conversion_control       <= next_conversion_control;
			converter_output_control <= next_converter_output_control;
			soft_reset               <= next_soft_reset;
		end
	end

	// read decode, other addresses answer zero
	// combinational, so a read sees a write taken on the edge before
	always_comb
	begin
		if (reg_addr == MCCR_ADDR_CONV_CTRL)
		begin
			reg_rdata = conversion_control;
		end
		else if (reg_addr == MCCR_ADDR_OUT_CTRL)
		begin
			reg_rdata = converter_output_control;
		end
		else
		begin
			reg_rdata = 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// field decode
	logic [2:0] sel;       // single channel code
	logic       pin9_ain;  // pin 9 used as converter input
	logic       monitor;   // monitoring started
	assign sel            = conversion_control[MCCR_SEL_LSB +: 3];
	assign pin9_ain       = first_control[MCCR_CC1_PIN9_BIT];
	assign monitor        = first_control[MCCR_CC1_START_BIT];
	assign single_mode    = conversion_control[MCCR_MODE_BIT];
	assign fast_adc       = converter_output_control[MCCR_FAST_BIT];
	// resolution only honoured when written; 8-bit-only variant tied off outside
	assign thermal_10bit  = converter_output_control[MCCR_RES10_BIT];
	// pin 9 as converter input masks the load source bit
	// both load selects low then, so the dac side holds its outputs
	assign load_from_regs = converter_output_control[MCCR_LOADSRC_BIT] && !pin9_ain;
	assign load_from_pin  = !converter_output_control[MCCR_LOADSRC_BIT] && !pin9_ain;
	assign adc_ref_supply = converter_output_control[MCCR_VREFDD_BIT];
	assign dac_a_track    = converter_output_control[MCCR_TRACKA_BIT];
	assign dac_b_track    = converter_output_control[MCCR_TRACKB_BIT];
	// averaging off gives single conversions
	assign avg_count = conversion_control[MCCR_AVGDIS_BIT] ? 5'h01 : 5'(AVG_COUNT);

	// source resolution, bit 0 supply, 1 internal, 2 external sensor,
	// bits 3 to 6 inputs one to four; the shared code looks at the pin
	// function so software need not know which sensor is fitted
	always_comb
	begin
		conv_source = 7'h00;
		case (sel)
			MCCR_CH_SUPPLY: conv_source[0] = 1'b1;
			MCCR_CH_INT:    conv_source[1] = 1'b1;
			MCCR_CH_EXT1:  // external sensor or first input
			begin
				if (first_control[MCCR_CC1_PIN78_LSB +: 2] == MCCR_PIN78_EXT_SENSOR)
					conv_source[2] = 1'b1;
				else
					conv_source[3] = 1'b1;
			end
			MCCR_CH_INPUT_TWO:   conv_source[4] = 1'b1;
			MCCR_CH_INPUT_THREE: conv_source[5] = 1'b1;
			MCCR_CH_INPUT_FOUR:  conv_source[6] = 1'b1;
			default:        conv_source = 7'h00;  // reserved codes convert nothing
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// conversion sequencing state
	mccr_state_t state;
	mccr_state_t next_state;

	// next state: idle until monitoring starts, then follow the mode bit
	always_comb
	begin
		next_state = state;
		case (state)
			MCCR_ST_IDLE:
			begin
				// powers up in round robin but waits for the start bit
				if (monitor)
				begin
					next_state = single_mode ? MCCR_ST_ONE : MCCR_ST_RR;
				end
			end
			MCCR_ST_RR:
			begin
				if (!monitor)
				begin
					next_state = MCCR_ST_IDLE;  // stop request
				end
				else if (single_mode)
				begin
					next_state = MCCR_ST_ONE;
				end
			end
			MCCR_ST_ONE:
			begin
				if (!monitor)
				begin
					next_state = MCCR_ST_IDLE;  // stop request
				end
				else if (!single_mode)
				begin
					next_state = MCCR_ST_RR;
				end
			end
			default:
			begin
				next_state = MCCR_ST_IDLE;  // stray code recovers to idle
			end
		endcase
	end

	// state register; a mode change mid-run takes one cycle
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state <= MCCR_ST_IDLE;
		end
		else
		begin
			state <= next_state;
		end
	end

	// conversion clock; idle keeps it silent
	// the divider restarts from zero on every start, so the first tick
	// comes one full period after the state leaves idle
	mccr_tick_div #(
		.SLOW_DIV (SLOW_DIV),
		.FAST_DIV (FAST_DIV)
	) mccr_tick_div_inst (
		.clk   (clk),
		.reset (reset),
		.run   (state != MCCR_ST_IDLE && monitor),
		.fast  (fast_adc),
		.tick  (conv_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// serial clock timeout
	logic [31:0] low_count;
	logic [31:0] next_low_count;
	logic        next_bus_abort;

	// count clock-low cycles inside a transfer
	// the count restarts after each abort, so a clock stuck low keeps
	// aborting once per period until the host lets it go
	// a clock that rises, or a transfer that ends, clears the count at once
	always_comb
	begin
		next_low_count = 32'h0000_0000;
		next_bus_abort = 1'b0;
		if (conversion_control[MCCR_TMO_BIT] && in_transaction && serial_clock_low)
		begin
			if (low_count >= 32'(TIMEOUT_CYC - 1))
				next_bus_abort = 1'b1;
			else
				next_low_count = low_count + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			low_count <= 32'h0000_0000;
			bus_abort <= 1'b0;
		end
		else
		begin
			low_count <= next_low_count;
			bus_abort <= next_bus_abort;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	write_masked_a: assert property (@(posedge clk) disable iff (reset)
		(reg_write && reg_addr == MCCR_ADDR_OUT_CTRL) |=> (converter_output_control[7] == 1'b0
		&& converter_output_control[2] == 1'b0))
		else $error("reserved bit stored");
	swreset_clear_a: assert property (@(posedge clk) disable iff (reset)
		(reg_write && reg_addr == MCCR_ADDR_CONV_CTRL && reg_wdata[7])
		|=> (converter_output_control == 8'h00 && conversion_control == 8'h00 && soft_reset))
		else $error("software reset did not clear");
	swreset_reads_a: assert property (@(posedge clk) disable iff (reset)
		conversion_control[MCCR_SWRST_BIT] == 1'b0)
		else $error("reset bit reads one");
	no_start_a: assert property (@(posedge clk) disable iff (reset)
		!monitor |=> !conv_tick [*2])
		else $error("conversion without start");
	ext_select_a: assert property (@(posedge clk) disable iff (reset)
		(sel == MCCR_CH_EXT1) |-> (conv_source[2] ^ conv_source[3]))
		else $error("ext/analog_input_one not resolved");
	reserved_sel_a: assert property (@(posedge clk) disable iff (reset)
		(sel > MCCR_CH_INPUT_FOUR) |-> conv_source == 7'h00)
		else $error("reserved select converts");
	load_mask_a: assert property (@(posedge clk) disable iff (reset)
		pin9_ain |-> !load_from_regs && !load_from_pin)
		else $error("load source not masked");
	avg_value_a: assert property (@(posedge clk) disable iff (reset)
		$rose(conversion_control[MCCR_AVGDIS_BIT]) |-> avg_count == 5'h01)
		else $error("averaging not disabled");
	timeout_off_a: assert property (@(posedge clk) disable iff (reset)
		!conversion_control[MCCR_TMO_BIT] |=> !bus_abort)
		else $error("abort with timeout disabled");
	mode_follow_a: assert property (@(posedge clk) disable iff (reset)
		(monitor && single_mode) [*2] |=> state == MCCR_ST_ONE)
		else $error("single mode not entered");
	cover_single_c: cover property (@(posedge clk) state == MCCR_ST_ONE && conv_tick);
	cover_rr_c:     cover property (@(posedge clk) state == MCCR_ST_RR && conv_tick);
	cover_abort_c:  cover property (@(posedge clk) bus_abort);
	cover_swrst_c:  cover property (@(posedge clk) soft_reset);
	cover_ext_c:    cover property (@(posedge clk) sel == MCCR_CH_EXT1 && conv_source[2]);
endmodule // mccr_regs

// File: hdl/mccr_pkg.sv
// package for the conversion configuration register bank
// assumes a single 200 MHz clock and 8-bit register data
package mccr_pkg;
	localparam logic [7:0] MCCR_ADDR_CONV_CTRL = 8'h19;  // conversion_control
	localparam logic [7:0] MCCR_ADDR_OUT_CTRL  = 8'h1a;  // converter_output_control
	localparam logic [7:0] MCCR_RESET_VALUE    = 8'h00;  // every bit cleared at power-up
	// conversion_control fields
	localparam int MCCR_SEL_LSB     = 0;  // single channel select, 3 bits
	localparam int MCCR_MODE_BIT    = 4;  // 1 = single channel
	localparam int MCCR_AVGDIS_BIT  = 5;  // 1 = no averaging
	localparam int MCCR_TMO_BIT     = 6;  // 1 = bus timeout enabled
	localparam int MCCR_SWRST_BIT   = 7;  // software reset
	localparam logic [7:0] MCCR_CONV_WMASK = 8'h77;  // reserved 3 and self-clearing 7 masked
	// converter_output_control fields
	localparam int MCCR_FAST_BIT    = 0;  // fast adc clock
	localparam int MCCR_RES10_BIT   = 1;  // 10-bit thermal output
	localparam int MCCR_LOADSRC_BIT = 3;  // 1 = registers drive dac load
	localparam int MCCR_VREFDD_BIT  = 4;  // 1 = supply as adc reference
	localparam int MCCR_TRACKA_BIT  = 5;  // dac a follows internal temp
	localparam int MCCR_TRACKB_BIT  = 6;  // dac b follows external temp
	localparam logic [7:0] MCCR_OUT_WMASK = 8'h7b;  // reserved 2 and 7 masked
	// first control register pin-function bits used here
	localparam int MCCR_CC1_START_BIT  = 0;  // monitoring start
	localparam int MCCR_CC1_PIN78_LSB  = 1;  // 2-bit pin 7/8 function
	localparam int MCCR_CC1_PIN9_BIT   = 3;  // 1 = pin 9 is the third converter input
	localparam logic [1:0] MCCR_PIN78_EXT_SENSOR = 2'b10;  // external sensor on pins 7/8
	// channel codes
	localparam logic [2:0] MCCR_CH_SUPPLY = 3'h0;
	localparam logic [2:0] MCCR_CH_INT    = 3'h1;
	localparam logic [2:0] MCCR_CH_EXT1   = 3'h2;
	localparam logic [2:0] MCCR_CH_INPUT_TWO   = 3'h3;
	localparam logic [2:0] MCCR_CH_INPUT_THREE = 3'h4;
	localparam logic [2:0] MCCR_CH_INPUT_FOUR  = 3'h5;
	// resolved source one-hot index
	localparam int MCCR_SRC_W = 7;  // supply, internal, external, inputs one to four
	// averaging and clock figures
	localparam int MCCR_AVG_COUNT = 16;
	localparam real MCCR_CLK_HZ      = 200.0e6;
	localparam real MCCR_SLOW_HZ     = 1.4e3;
	localparam real MCCR_FAST_HZ     = 22.5e3;
	localparam real MCCR_TIMEOUT_MS  = 25.0;
	localparam int MCCR_SLOW_DIV = int'(MCCR_CLK_HZ / MCCR_SLOW_HZ);  // ~142857
	localparam int MCCR_FAST_DIV = int'(MCCR_CLK_HZ / MCCR_FAST_HZ);  // ~8889
	// longest time rounds down
	localparam int MCCR_TIMEOUT_CYC = $rtoi(MCCR_TIMEOUT_MS * 1.0e-3 * MCCR_CLK_HZ);
	typedef enum logic [2:0]
	{
		MCCR_ST_IDLE = 3'b001,  // monitoring stopped
		MCCR_ST_RR   = 3'b010,  // round robin
		MCCR_ST_ONE  = 3'b100   // single channel
	} mccr_state_t;
endpackage

// File: hdl/mccr_tick_div.sv
// enable-pulse divider for the adc conversion clock
// assumes the period is picked by a level that may change any time
module mccr_tick_div
	import mccr_pkg::*;
#(
	parameter int SLOW_DIV = MCCR_SLOW_DIV,
	parameter int FAST_DIV = MCCR_FAST_DIV
)
(
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic run,   // counting allowed
	input  wire logic fast,  // pick short period
	output logic      tick   // one-cycle enable
);
	logic [31:0] count;       // cycles since last tick
	logic [31:0] next_count;
	logic        next_tick;
	logic [31:0] limit;       // period minus one

	// next count and tick
	always_comb
	begin
		limit      = fast ? 32'(FAST_DIV - 1) : 32'(SLOW_DIV - 1);
		next_count = count;
		next_tick  = 1'b0;
		if (!run)
		begin
			next_count = 32'h0000_0000;
		end
		else if (count >= limit)  // >= covers a fast switch mid count
		begin
			next_count = 32'h0000_0000;
			next_tick  = 1'b1;
		end
		else
		begin
			next_count = count + 32'h0000_0001;
		end
	end

	// register
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			count <= 32'h0000_0000;
			tick  <= 1'b0;
		end
		else
		begin
			count <= next_count;
			tick  <= next_tick;
		end
	end
endmodule // mccr_tick_div

// File: verif/mccr_regs_tb_top.sv
// self-checking bench for the conversion configuration register bank
// assumes reads are combinational and writes are taken on the rising edge
module mccr_regs_tb_top
	import mccr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	////////////////////////////////////////////////////////////////////////////
	localparam int TMO   = 50;     // shortened bus timeout
	localparam int SLOW  = 20;     // shortened slow divider
	localparam int FAST  = 5;      // shortened fast divider
	localparam int LIMIT = 10000;  // hang ceiling, run needs about 390
	logic       clk;               // 200 MHz
	logic       reset;             // async, active high
	logic [7:0] reg_addr;          // register address
	logic       reg_write;         // write strobe
	logic [7:0] reg_wdata;         // write data
	logic [7:0] reg_rdata;         // read data
	logic [7:0] first_control;     // pin function bits
	logic       serial_clock_low;  // bus clock stuck low
	logic       in_transaction;    // transfer open
	logic       bus_abort, soft_reset, conv_tick, single_mode, fast_adc, thermal_10bit;
	logic       load_from_regs, load_from_pin, adc_ref_supply, dac_a_track, dac_b_track;
	logic [6:0] conv_source;       // one-hot source
	logic [4:0] avg_count;         // results per measurement
	logic [7:0] flags;             // level outputs packed for one compare
	int         n_fail;            // mismatches
	int         compares;          // comparisons made
	int         cycles;            // watchdog count
	logic [7:0] wtab [6];          // one field bit at a time
	logic [7:0] ftab [6];          // flags expected for each
	assign flags = {single_mode, fast_adc, thermal_10bit, load_from_regs,
		load_from_pin, adc_ref_supply, dac_a_track, dac_b_track};
	////////////////////////////////////////////////////////////////////////////
	mccr_regs #(.TIMEOUT_CYC(TMO), .SLOW_DIV(SLOW), .FAST_DIV(FAST)) mccr_regs_inst
	(
		.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_write(reg_write),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .first_control(first_control),
		.serial_clock_low(serial_clock_low), .in_transaction(in_transaction),
		.bus_abort(bus_abort), .soft_reset(soft_reset), .conv_tick(conv_tick),
		.conv_source(conv_source), .single_mode(single_mode), .avg_count(avg_count),
		.fast_adc(fast_adc), .thermal_10bit(thermal_10bit),
		.load_from_regs(load_from_regs), .load_from_pin(load_from_pin),
		.adc_ref_supply(adc_ref_supply), .dac_a_track(dac_a_track),
		.dac_b_track(dac_b_track)
	);
	// free-running clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////
	// case-equal compare, so an unknown never matches
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// strobe held one cycle, taken at the second edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	// address set at the edge, data looked at mid-cycle
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
		@(posedge clk);
		reg_addr <= a;
		@(negedge clk);
		chk(reg_rdata, e, what);
	endtask
	// levels settled mid-cycle
	task automatic chkf(input logic [7:0] e, input string what);
		@(negedge clk);
		chk(flags, e, what);
	endtask
	// pin inputs change only at the rising edge
	task automatic pins(input logic [7:0] fc, input logic hold);
		@(posedge clk);
		first_control    <= fc;
		in_transaction   <= hold;
		serial_clock_low <= hold;
	endtask
	function automatic logic pulse(input bit sel);
		return sel ? bus_abort : conv_tick;
	endfunction
	// cycles between two pulses, each wait bounded
	task automatic gap(input bit sel, input int exp, input string what);
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pulse(sel) !== 1'b1 && n < 400);
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pulse(sel) !== 1'b1 && n < 400);
		chk(8'(n), 8'(exp), what);
	endtask
	// no pulse at all over a stretch
	task automatic quiet(input bit sel, input int len, input string what);
		int cnt;
		cnt = 0;
		repeat (len)
		begin
			@(posedge clk);
			if (pulse(sel) !== 1'b0)
			begin
				cnt++;
			end
		end
		chk(8'(cnt), 8'h00, what);
	endtask
	// closing report, reached from the end or the watchdog
	task automatic finish_test();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// watchdog: a hang counts as a mismatch
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			n_fail++;
			$display("BAD t=%0t watchdog expired", $time);
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		logic [6:0] es;  // expected one-hot source
		n_fail           = 0;
		compares         = 0;
		cycles           = 0;
		reset            = 1'b1;
		reg_addr         = 8'h00;
		reg_write        = 1'b0;
		reg_wdata        = 8'h00;
		first_control    = 8'h00;
		serial_clock_low = 1'b0;
		in_transaction   = 1'b0;
		wtab = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h20, 8'h40};
		ftab = '{8'h48, 8'h28, 8'h10, 8'h0c, 8'h0a, 8'h09};
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		// power-up values and an unmapped address
		rd(MCCR_ADDR_CONV_CTRL, MCCR_RESET_VALUE, "conv reset");
		rd(MCCR_ADDR_OUT_CTRL, MCCR_RESET_VALUE, "out reset");
		rd(8'h18, 8'h00, "unmapped read");
		chkf(8'h08, "flags at reset");
		chk({3'h0, avg_count}, 8'h10, "averaging default");
		$display("test reset values done");
		// reserved bits never stored
		wr(MCCR_ADDR_CONV_CTRL, 8'h7f);
		rd(MCCR_ADDR_CONV_CTRL, 8'h77, "conv reserved");
		chk({3'h0, avg_count}, 8'h01, "averaging off");
		wr(MCCR_ADDR_OUT_CTRL, 8'hff);
		rd(MCCR_ADDR_OUT_CTRL, 8'h7b, "out reserved");
		chkf(8'hf7, "all fields set");
		wr(MCCR_ADDR_CONV_CTRL, 8'h00);
		// each output field alone catches swapped bits
		for (int i = 0; i < 6; i++)
		begin
			wr(MCCR_ADDR_OUT_CTRL, wtab[i]);
			chkf(ftab[i], "single field");
		end
		$display("test field map done");
		// every select code, both pin 7/8 functions
		for (int p = 0; p < 2; p++)
		begin
			pins(p ? 8'h04 : 8'h00, 1'b0);
			for (int c = 0; c < 8; c++)
			begin
				es = (c < 2) ? 7'(1 << c) : (c == 2) ? (p ? 7'h04 : 7'h08) :
					(c < 6) ? 7'(1 << (c + 1)) : 7'h00;
				wr(MCCR_ADDR_CONV_CTRL, 8'(8'h10 | c));
				@(negedge clk);
				chk({1'b0, conv_source}, {1'b0, es}, "source select");
			end
		end
		$display("test channel select done");
		// load source masked while pin 9 is a converter input
		pins(8'h08, 1'b0);
		wr(MCCR_ADDR_OUT_CTRL, 8'h08);
		chkf(8'h80, "load masked");
		pins(8'h00, 1'b0);
		chkf(8'h90, "load unmasked");
		// software reset clears everything and reads back zero
		wr(MCCR_ADDR_OUT_CTRL, 8'h7b);
		wr(MCCR_ADDR_CONV_CTRL, 8'h80);
		@(negedge clk);
		chk({7'h00, soft_reset}, 8'h01, "soft reset pulse");
		@(negedge clk);
		chk({7'h00, soft_reset}, 8'h00, "soft reset ends");
		rd(MCCR_ADDR_CONV_CTRL, 8'h00, "conv after reset");
		rd(MCCR_ADDR_OUT_CTRL, 8'h00, "out after reset");
		$display("test software reset done");
		// conversions only after start, period set by speed bit
		quiet(1'b0, 3 * SLOW, "no tick before start");
		pins(8'h01, 1'b0);
		gap(1'b0, SLOW, "slow period");
		wr(MCCR_ADDR_OUT_CTRL, 8'h01);
		gap(1'b0, FAST, "fast period");
		// single channel mode keeps the conversion clock running
		wr(MCCR_ADDR_CONV_CTRL, 8'h10);
		gap(1'b0, FAST, "single mode period");
		pins(8'h00, 1'b0);
		wr(MCCR_ADDR_OUT_CTRL, 8'h00);
		$display("test conversion clock done");
		// stuck bus clock aborts only when enabled
		pins(8'h00, 1'b1);
		quiet(1'b1, TMO + 20, "no abort when off");
		wr(MCCR_ADDR_CONV_CTRL, 8'h40);
		// the count restarts after each abort, so aborts repeat every TMO
		gap(1'b1, TMO, "abort repeat");
		pins(8'h00, 1'b0);
		$display("test bus timeout done");
		finish_test();
	end
endmodule  // mccr_regs_tb_top
